// ### hdl/ecc_current_source_regs.vh
// register address, reset value and bit positions of the current source control
`ifndef ECC_CURRENT_SOURCE_REGS_VH
`define ECC_CURRENT_SOURCE_REGS_VH

`define ECC_CURRENT_SOURCE_CONTROL_ADDR 8'hD5
`define ECC_CURRENT_SOURCE_CONTROL_RESET 8'h00

`define ECC_BIT_RESERVED 7
`define ECC_BIT_BURNOUT_ENABLE 6
`define ECC_BIT_AUX_CURRENT_CORRECTION 5
`define ECC_BIT_PRIMARY_CURRENT_CORRECTION 4
`define ECC_BIT_SOURCE_TWO_PIN_SELECT 3
`define ECC_BIT_SOURCE_ONE_PIN_SELECT 2
`define ECC_BIT_SOURCE_TWO_ENABLE 1
`define ECC_BIT_SOURCE_ONE_ENABLE 0

// reserved bit is not stored and reads as zero
`define ECC_WRITABLE_MASK 8'h7F

`endif

// ### hdl/ecc_current_source_control.v
// current source control register and its static analog control lines
`default_nettype none
`include "ecc_current_source_regs.vh"

module ecc_current_source_control (
  input wire clk,
  input wire srst,
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  output reg [7:0] regReadData,
  output reg burnoutEnable,
  output reg auxCurrentCorrection,
  output reg primaryCurrentCorrection,
  output reg sourceOneEnable,
  output reg sourceTwoEnable,
  output reg sourceOneToFirstPin,
  output reg sourceOneToSecondPin,
  output reg sourceTwoToFirstPin,
  output reg sourceTwoToSecondPin
);

  // stored byte; bit 7 is loaded from the masked write byte, so it stays at its reset zero
  reg [7:0] currentSourceControl;

  // strobes qualified by the address decode
  wire hit;
  wire writeHit;
  wire readHit;

  // write byte with the reserved bit removed
  wire [7:0] next_control;

  // per-line next values, one bit of the write byte each
  wire next_burnout;
  wire next_auxCorrection;
  wire next_primaryCorrection;
  wire next_s2Enable;
  wire next_s1Enable;

  // routing next values; each pair is complementary
  wire next_s1First;
  wire next_s1Second;
  wire next_s2First;
  wire next_s2Second;

  // byte offered on the read port in the next cycle
  wire [7:0] next_readData;

  // reset levels derived from the cleared byte, not typed in twice
  localparam [7:0] RESET_BYTE = `ECC_CURRENT_SOURCE_CONTROL_RESET;

  // analog enables start off with the byte
  localparam [0:0] RST_BURNOUT =
    RESET_BYTE[`ECC_BIT_BURNOUT_ENABLE];
  localparam [0:0] RST_AUX =
    RESET_BYTE[`ECC_BIT_AUX_CURRENT_CORRECTION];
  localparam [0:0] RST_PRIMARY =
    RESET_BYTE[`ECC_BIT_PRIMARY_CURRENT_CORRECTION];
  localparam [0:0] RST_S1_EN =
    RESET_BYTE[`ECC_BIT_SOURCE_ONE_ENABLE];
  localparam [0:0] RST_S2_EN =
    RESET_BYTE[`ECC_BIT_SOURCE_TWO_ENABLE];

  // a cleared select still routes each source to exactly one pin
  localparam [0:0] RST_S1_FIRST =
    ~RESET_BYTE[`ECC_BIT_SOURCE_ONE_PIN_SELECT];
  localparam [0:0] RST_S1_SECOND =
    RESET_BYTE[`ECC_BIT_SOURCE_ONE_PIN_SELECT];
  localparam [0:0] RST_S2_FIRST =
    RESET_BYTE[`ECC_BIT_SOURCE_TWO_PIN_SELECT];
  localparam [0:0] RST_S2_SECOND =
    ~RESET_BYTE[`ECC_BIT_SOURCE_TWO_PIN_SELECT];

  // byte-wide decode only; there is no bit-addressed path into this register
  assign hit = (regAddr == `ECC_CURRENT_SOURCE_CONTROL_ADDR);

  // other addresses fall through untouched, so only hits qualify
  assign writeHit = regWrite & hit;
  assign readHit = regRead & hit;

  // reserved bit dropped so it can never steer anything
  assign next_control = regWriteData & `ECC_WRITABLE_MASK;

  // one bit drives both burnout sources, so they switch together
  assign next_burnout = next_control[`ECC_BIT_BURNOUT_ENABLE];

  // corrections only gate the scaling; the word itself lives elsewhere
  assign next_auxCorrection =
    next_control[`ECC_BIT_AUX_CURRENT_CORRECTION];
  assign next_primaryCorrection =
    next_control[`ECC_BIT_PRIMARY_CURRENT_CORRECTION];

  // one enable bit per excitation source
  assign next_s2Enable = next_control[`ECC_BIT_SOURCE_TWO_ENABLE];
  assign next_s1Enable = next_control[`ECC_BIT_SOURCE_ONE_ENABLE];

  // a set select moves source two onto the first pin
  assign next_s2First = next_control[`ECC_BIT_SOURCE_TWO_PIN_SELECT];
  assign next_s2Second = ~next_s2First;

  // opposite sense: a set select moves source one onto the second pin
  assign next_s1Second = next_control[`ECC_BIT_SOURCE_ONE_PIN_SELECT];
  assign next_s1First = ~next_s1Second;

  // a read and a write in one cycle return the byte before the write
  assign next_readData = readHit ? currentSourceControl : 8'h00;

  // stored byte, loaded whole on every write hit
  always @(posedge clk) begin
    if (srst) begin
      currentSourceControl <= RESET_BYTE;
    end else if (writeHit) begin
      currentSourceControl <= next_control;
    end
  end

  // burnout pair follows its bit and holds between writes
  always @(posedge clk) begin
    if (srst) begin
      burnoutEnable <= RST_BURNOUT;
    end else if (writeHit) begin
      burnoutEnable <= next_burnout;
    end
  end

  // auxiliary correction enable, static between writes
  always @(posedge clk) begin
    if (srst) begin
      auxCurrentCorrection <= RST_AUX;
    end else if (writeHit) begin
      auxCurrentCorrection <= next_auxCorrection;
    end
  end

  // primary correction enable, static between writes
  always @(posedge clk) begin
    if (srst) begin
      primaryCurrentCorrection <= RST_PRIMARY;
    end else if (writeHit) begin
      primaryCurrentCorrection <= next_primaryCorrection;
    end
  end

  // source two on or off
  always @(posedge clk) begin
    if (srst) begin
      sourceTwoEnable <= RST_S2_EN;
    end else if (writeHit) begin
      sourceTwoEnable <= next_s2Enable;
    end
  end

  // source one on or off
  always @(posedge clk) begin
    if (srst) begin
      sourceOneEnable <= RST_S1_EN;
    end else if (writeHit) begin
      sourceOneEnable <= next_s1Enable;
    end
  end

  // no lockout against source one: currents may sum on a pin
  always @(posedge clk) begin
    if (srst) begin
      sourceTwoToFirstPin <= RST_S2_FIRST;
    end else if (writeHit) begin
      sourceTwoToFirstPin <= next_s2First;
    end
  end

  // complement of the line above, so source two sits on one pin
  always @(posedge clk) begin
    if (srst) begin
      sourceTwoToSecondPin <= RST_S2_SECOND;
    end else if (writeHit) begin
      sourceTwoToSecondPin <= next_s2Second;
    end
  end

  // no lockout against source two either
  always @(posedge clk) begin
    if (srst) begin
      sourceOneToSecondPin <= RST_S1_SECOND;
    end else if (writeHit) begin
      sourceOneToSecondPin <= next_s1Second;
    end
  end

  // complement of the line above, so source one sits on one pin
  always @(posedge clk) begin
    if (srst) begin
      sourceOneToFirstPin <= RST_S1_FIRST;
    end else if (writeHit) begin
      sourceOneToFirstPin <= next_s1First;
    end
  end

  // read data registered: valid one cycle after a read request
  always @(posedge clk) begin
    if (srst) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= next_readData;
    end
  end

endmodule
`default_nettype wire

// ### test/ecc_csc_sva.sv
// assertions on the current source control register ports
`default_nettype none
module ecc_csc_sva(
  input wire logic clk,
  input wire logic srst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic burnoutEnable,
  input wire logic auxCurrentCorrection,
  input wire logic primaryCurrentCorrection,
  input wire logic sourceOneEnable,
  input wire logic sourceTwoEnable,
  input wire logic sourceOneToSecondPin,
  input wire logic sourceTwoToFirstPin,
  input wire logic sourceOneToFirstPin,
  input wire logic sourceTwoToSecondPin
);
  timeunit 1ns / 1ps;
  // hits on the register; q is the byte that the outputs stand for
  wire logic w = regWrite && regAddr == 8'hD5;
  wire logic r = regRead && regAddr == 8'hD5;
  wire logic [7:0] d = regWriteData;
  wire logic [7:0] q = {1'b0, burnoutEnable, auxCurrentCorrection,
    primaryCurrentCorrection, sourceTwoToFirstPin, sourceOneToSecondPin,
    sourceTwoEnable, sourceOneEnable};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  reset_clear_a: assert property (disable iff (0) srst |=> q == 8'h00)
    else $error("reset state wrong");
  upper_take_a: assert property (w |=> q[6:4] == $past(d[6:4]))
    else $error("burnout or correction wrong");
  pin_take_a: assert property (w |=> q[3:2] == $past(d[3:2]))
    else $error("pin select wrong");
  enable_take_a: assert property (w |=> q[1:0] == $past(d[1:0]))
    else $error("source enable wrong");
  pin_pair_a: assert property (sourceOneToFirstPin ^ q[2])
    else $error("source one routed twice");
  pair_two_a: assert property (sourceTwoToSecondPin ^ q[3])
    else $error("source two routed twice");
  hold_static_a: assert property (!w |=> $stable(q))
    else $error("outputs moved without write");
  read_back_a: assert property (r |=> regReadData == $past(q))
    else $error("read data wrong");
  read_idle_a: assert property (!r |=> regReadData == 8'h00)
    else $error("read data not idle");
  cover property (w ##2 r);
  cover property (sourceOneToFirstPin && sourceTwoToFirstPin);
  cover property (q[2] && !q[3]);
endmodule
bind ecc_current_source_control ecc_csc_sva i_ecc_csc_sva(.*);
`default_nettype wire

// ### test/ecc_pin_model.sv
// analog side: current on each excitation pin in microamps
`default_nettype none
module ecc_pin_model(
  input wire logic sourceOneEnable,
  input wire logic sourceTwoEnable,
  input wire logic sourceOneToFirstPin,
  input wire logic sourceTwoToFirstPin,
  input wire logic sourceOneToSecondPin,
  input wire logic sourceTwoToSecondPin,
  output logic [9:0] firstUa,
  output logic [9:0] secondUa
);
  timeunit 1ns / 1ps;
  // sources add on a shared pin, nothing locks them apart
  assign firstUa = 10'(200 * (sourceOneEnable & sourceOneToFirstPin) +
    200 * (sourceTwoEnable & sourceTwoToFirstPin));
  // second pin sums the same way; a doubly routed source shows twice
  assign secondUa = 10'(200 * (sourceOneEnable & sourceOneToSecondPin) +
    200 * (sourceTwoEnable & sourceTwoToSecondPin));
endmodule
`default_nettype wire

// ### test/tb_top.sv
// bench for the current source control register
`default_nettype none
module tb_top;
  timeunit 1ns / 1ps;
  logic clk = 0, srst = 1, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 8'h00, regWriteData = 8'h00;
  wire logic [7:0] regReadData;
  wire logic [9:0] firstUa;
  wire logic [9:0] secondUa;
  wire logic burnoutEnable, auxCurrentCorrection, primaryCurrentCorrection,
    sourceOneEnable, sourceTwoEnable, sourceOneToFirstPin,
    sourceOneToSecondPin, sourceTwoToFirstPin, sourceTwoToSecondPin;
  int n_mismatch = 0, compares = 0;
  always #20 clk = ~clk;
  ecc_current_source_control i_ecc_current_source_control(.*);
  ecc_pin_model i_ecc_pin_model(.*);
  // one-cycle strobe, then settle past the answering edge
  task automatic bus(input logic w, input logic [7:0] a, dat);
    @(posedge clk) {regWrite, regRead, regAddr, regWriteData} <=
      {w, !w, a, dat};
    @(posedge clk) {regWrite, regRead} <= 2'b00;
    #1;
  endtask
  task automatic cmp(input logic [9:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // reset value, then an unmapped write and read leave it alone
  task automatic unmapped;
    bus(0, 8'hD5, 8'h00);
    cmp(regReadData, 10'h000);
    bus(1, 8'hD4, 8'hFF);
    cmp({burnoutEnable, auxCurrentCorrection, primaryCurrentCorrection},
      10'h000);
    bus(0, 8'hD4, 8'h00);
    cmp(regReadData, 10'h000);
    bus(0, 8'hD5, 8'h00);
    cmp(regReadData, 10'h000);
  endtask
  // every byte: read back, upper controls and summed pin current
  task automatic sweep;
    for (int v = 0; v < 256; v++) begin
      bus(1, 8'hD5, 8'(v));
      bus(0, 8'hD5, 8'h00);
      cmp(regReadData, 10'(v & 8'h7F));
      cmp({burnoutEnable, auxCurrentCorrection, primaryCurrentCorrection},
        10'(v[6:4]));
      cmp(firstUa,
        10'(200 * (v[0] & ~v[2]) + 200 * (v[1] & v[3])));
      cmp(secondUa,
        10'(200 * (v[0] & v[2]) + 200 * (v[1] & ~v[3])));
    end
  endtask
  // all seven writable bits set, a stray read elsewhere, then a reset in mid-run
  task automatic reset_mid;
    bus(1, 8'hD5, 8'h7F);
    bus(0, 8'hD4, 8'h00);
    cmp(regReadData, 10'h000);
    cmp(firstUa, 10'h0C8);
    cmp(secondUa, 10'h0C8);
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    cmp({burnoutEnable, auxCurrentCorrection, primaryCurrentCorrection},
      10'h000);
    cmp(firstUa, 10'h000);
    cmp(secondUa, 10'h000);
    cmp({sourceOneToFirstPin, sourceTwoToSecondPin}, 10'h003);
    bus(0, 8'hD5, 8'h00);
    cmp(regReadData, 10'h000);
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded run: a hang counts as a mismatch
  initial begin #200us; n_mismatch++; stop_test; end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    unmapped;
    sweep;
    reset_mid;
    stop_test;
  end
endmodule
`default_nettype wire
